//--- adcc_pkg.sv
package adcc_pkg;

    // Module register addresses, low byte of the address port
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_DATA1 = 8'h01;
    localparam logic [7:0] ADDR_C1A   = 8'h02;
    localparam logic [7:0] ADDR_C1B   = 8'h03;
    localparam logic [7:0] ADDR_DATA2 = 8'h04;
    localparam logic [7:0] ADDR_C2A   = 8'h05;
    localparam logic [7:0] ADDR_C2B   = 8'h06;
    localparam logic [7:0] ADDR_DATAT = 8'h07;
    localparam logic [7:0] ADDR_CTA   = 8'h08;
    localparam logic [7:0] ADDR_CTB   = 8'h09;
    localparam int         ADDR_W     = 8;

    // Reset values
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_CFGA = 16'h0000;
    localparam logic [15:0] RST_CFGB = 16'h0070;
    localparam logic [15:0] RST_DATA = 16'h0000;

    // Writable bits; the rest read as zero
    localparam logic [15:0] MASK_CTRL = 16'h0F07;
    localparam logic [15:0] MASK_CFGA = 16'hFF7F;
    localparam logic [15:0] MASK_CFGB = 16'h0073;
    localparam logic [15:0] MASK_CTA  = 16'h077F;
    localparam logic [15:0] MASK_CTB  = 16'h0070;

    // Field positions
    localparam int START_ONE  = 2;
    localparam int START_TWO  = 1;
    localparam int START_TEMP = 0;
    localparam int SE_LSB     = 8;
    localparam int GAIN_LSB   = 11;
    localparam int CLK_LSB    = 8;
    localparam int RES_LSB    = 4;
    localparam int OFF_SIGN   = 3;
    localparam int OFF_LSB    = 0;
    localparam int BIAS_LSB   = 4;
    localparam int REF_LSB    = 0;
    localparam int ACT_GO     = 15;
    localparam int ACT_READ   = 14;

    // Source selector codes
    localparam logic [3:0] SE_DIFF     = 4'h0;
    localparam logic [3:0] SE_FIXED_LO = 4'h4;
    localparam logic [3:0] SE_FIXED_HI = 4'h7;

    // Converter clock divisor for code 000, doubled per step
    localparam logic [9:0] DIV_BASE = 10'h004;

    // Converter clocks per conversion by resolution code
    localparam logic [11:0] RES_CLOCKS [0:7] = '{12'h100, 12'h140, 12'h200, 12'h280,
                                                 12'h320, 12'h500, 12'h800, 12'h800};

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_STORE = 3'b100
    } adcc_state_t;

    typedef enum logic [2:0] {
        TGT_ONE  = 3'b001,
        TGT_TWO  = 3'b010,
        TGT_TEMP = 3'b100
    } adcc_target_t;

endpackage : adcc_pkg

//--- adcc_conv_timer.sv
`timescale 1ns/100ps
`default_nettype none
module adcc_conv_timer #(
    parameter int DIV_SHIFT = 0
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Control
    input  wire logic       start,
    input  wire logic [2:0] clock_code,
    input  wire logic [2:0] res_code,
    // Status
    output var  logic       tick,
    output var  logic       done
);

    logic [9:0]  period_nxt;
    logic [9:0]  period_r;
    logic [9:0]  div_cnt_r;
    logic [11:0] adc_cnt_r;
    logic [11:0] total_r;
    logic        busy_r;

    // Divisor doubles per code step, shortened only for simulation
    always_comb
    begin
        period_nxt = (adcc_pkg::DIV_BASE << clock_code) >> DIV_SHIFT; // [RL19]
        if (period_nxt == 10'h000)
        begin
            period_nxt = 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy_r    <= 1'b0;
            period_r  <= 10'h001;
            total_r   <= 12'h001;
            div_cnt_r <= 10'h000;
            adc_cnt_r <= 12'h000;
            tick      <= 1'b0;
            done      <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            done <= 1'b0;
            if (start)
            begin
                busy_r    <= 1'b1;
                period_r  <= period_nxt;
                total_r   <= adcc_pkg::RES_CLOCKS[res_code]; // [RL20]
                div_cnt_r <= 10'h000;
                adc_cnt_r <= 12'h000;
            end
            else if (busy_r)
            begin
                if (div_cnt_r == period_r - 10'h001)
                begin
                    div_cnt_r <= 10'h000;
                    tick      <= 1'b1;
                    if (adc_cnt_r == total_r - 12'h001)
                    begin
                        busy_r <= 1'b0;
                        done   <= 1'b1;
                    end
                    else
                    begin
                        adc_cnt_r <= adc_cnt_r + 12'h001;
                    end
                end
                else
                begin
                    div_cnt_r <= div_cnt_r + 10'h001;
                end
            end
        end
    end

endmodule : adcc_conv_timer
`default_nettype wire

//--- adcc_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// RL1: control bits 11..8 hold source selector
// RL2: control bit 2 converts sensor one
// RL3: control bit 1 converts sensor two
// RL4: control bit 0 converts temperature
// RL5: processor halted while any conversion runs
// RL6: start bits self-clear when conversion completes
// RL7: sensor one wins; selector zero means pair one
// RL8: else sensor two; selector zero means pair two
// RL9: temperature only with selector zero
// RL10: nonzero selector converts single-ended source
// RL11: selector codes pick single-ended sources
// RL12: codes 0100..0111 force fixed reduced gain
// RL13: sensor one primary: gain, clock, resolution
// RL14: bit 3 offset sign, bits 2..0 magnitude
// RL15: sensor two primary uses same layout
// RL16: secondary: bias bits 6..4, reference 1..0
// RL17: temperature primary has no gain field
// RL18: temperature secondary holds only bias
// RL19: clock code divides system clock 4..512
// RL20: resolution code sets converter clock count
// RL21: indirect access, action bit self-clears
// RL22: result updates only at its completion
// RL23: unused bits ignore writes, read zero
module adcc_top #(
    parameter int DIV_SHIFT = 0
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Indirect module port
    input  wire logic [15:0] module_data_port,
    input  wire logic [15:0] module_address_port,
    input  wire logic        module_action_wr,
    input  wire logic [15:0] module_action_port,
    output var  logic        module_action_busy,
    output var  logic [15:0] module_read_data,
    output var  logic        module_read_strobe,
    output var  logic        cpu_halt,
    // Converter front end
    input  wire logic [15:0] conv_result_in,
    output var  logic        conv_active,
    output var  logic        conv_tick,
    output var  logic        fe_diff,
    output var  logic        fe_gain_fixed,
    output var  logic [4:0]  fe_gain,
    output var  logic [2:0]  fe_clock_code,
    output var  logic [2:0]  fe_resolution,
    output var  logic        fe_offset_sign,
    output var  logic [2:0]  fe_offset_magnitude,
    output var  logic [2:0]  fe_bias,
    output var  logic [1:0]  fe_reference,
    output var  logic [3:0]  fe_source,
    output var  logic [2:0]  fe_target
);

    logic                   rst_meta_r;
    logic                   rst_sync_b;
    logic [15:0]            ctrl_r;
    logic [15:0]            c1a_r;
    logic [15:0]            c1b_r;
    logic [15:0]            c2a_r;
    logic [15:0]            c2b_r;
    logic [15:0]            cta_r;
    logic [15:0]            ctb_r;
    logic [15:0]            data1_r;
    logic [15:0]            data2_r;
    logic [15:0]            datat_r;
    logic                   act_read_r;
    adcc_pkg::adcc_state_t  state_r;
    adcc_pkg::adcc_target_t tgt_r;
    adcc_pkg::adcc_target_t tgt_nxt;
    logic [3:0]             se;
    logic                   idle;
    logic                   launch_now;
    logic                   temp_drop;
    logic                   xfer;
    logic                   wr;
    logic [7:0]             addr;
    logic [15:0]            rd_val;
    logic [15:0]            sel_a;
    logic [15:0]            sel_b;
    logic                   timer_done;

    function automatic logic launches(input logic [15:0] c);
        return c[adcc_pkg::START_ONE] || c[adcc_pkg::START_TWO]
            || (c[adcc_pkg::START_TEMP] && c[adcc_pkg::SE_LSB +: 4] == adcc_pkg::SE_DIFF);
    endfunction : launches

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_b <= rst_meta_r;
        end
    end

    assign se         = ctrl_r[adcc_pkg::SE_LSB +: 4]; // [RL1]
    assign idle       = state_r == adcc_pkg::ST_IDLE;
    assign launch_now = idle && launches(ctrl_r); // [RL9]
    assign temp_drop  = idle && ctrl_r[adcc_pkg::START_TEMP] && !launch_now; // [RL9]
    assign xfer       = module_action_busy && idle && !launch_now; // [RL21]
    assign wr         = xfer && !act_read_r;
    assign addr       = module_address_port[adcc_pkg::ADDR_W-1:0];

    // Fixed priority among start bits
    always_comb
    begin
        if (ctrl_r[adcc_pkg::START_ONE])
        begin
            tgt_nxt = adcc_pkg::TGT_ONE; // [RL7] [RL2]
            sel_a   = c1a_r;
            sel_b   = c1b_r;
        end
        else if (ctrl_r[adcc_pkg::START_TWO])
        begin
            tgt_nxt = adcc_pkg::TGT_TWO; // [RL8] [RL3]
            sel_a   = c2a_r;
            sel_b   = c2b_r;
        end
        else
        begin
            tgt_nxt = adcc_pkg::TGT_TEMP; // [RL4]
            sel_a   = cta_r;
            sel_b   = ctb_r;
        end
    end

    // Action port: a new write beats the completion clear
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            module_action_busy <= 1'b0;
            act_read_r         <= 1'b0;
        end
        else if (module_action_wr)
        begin
            module_action_busy <= module_action_port[adcc_pkg::ACT_GO];
            act_read_r         <= module_action_port[adcc_pkg::ACT_READ];
        end
        else if (xfer)
        begin
            module_action_busy <= 1'b0; // [RL21]
        end
    end

    always_comb
    begin
        if (addr == adcc_pkg::ADDR_CTRL)
            rd_val = ctrl_r;
        else if (addr == adcc_pkg::ADDR_DATA1)
            rd_val = data1_r;
        else if (addr == adcc_pkg::ADDR_C1A)
            rd_val = c1a_r;
        else if (addr == adcc_pkg::ADDR_C1B)
            rd_val = c1b_r;
        else if (addr == adcc_pkg::ADDR_DATA2)
            rd_val = data2_r;
        else if (addr == adcc_pkg::ADDR_C2A)
            rd_val = c2a_r;
        else if (addr == adcc_pkg::ADDR_C2B)
            rd_val = c2b_r;
        else if (addr == adcc_pkg::ADDR_DATAT)
            rd_val = datat_r;
        else if (addr == adcc_pkg::ADDR_CTA)
            rd_val = cta_r;
        else if (addr == adcc_pkg::ADDR_CTB)
            rd_val = ctb_r;
        else
            rd_val = 16'h0000;
    end

    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            module_read_data   <= 16'h0000;
            module_read_strobe <= 1'b0;
        end
        else
        begin
            module_read_strobe <= xfer && act_read_r; // [RL21]
            if (xfer && act_read_r)
            begin
                module_read_data <= rd_val;
            end
        end
    end

    // Completion clears all start bits, including overridden ones
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            ctrl_r <= adcc_pkg::RST_CTRL;
        else if (wr && addr == adcc_pkg::ADDR_CTRL)
            ctrl_r <= module_data_port & adcc_pkg::MASK_CTRL; // [RL23]
        else if (state_r == adcc_pkg::ST_STORE)
            ctrl_r[adcc_pkg::START_ONE:adcc_pkg::START_TEMP] <= 3'h0; // [RL6]
        else if (temp_drop)
            ctrl_r[adcc_pkg::START_TEMP] <= 1'b0; // [RL9]
    end

    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            c1a_r <= adcc_pkg::RST_CFGA;
            c1b_r <= adcc_pkg::RST_CFGB;
            c2a_r <= adcc_pkg::RST_CFGA;
            c2b_r <= adcc_pkg::RST_CFGB;
            cta_r <= adcc_pkg::RST_CFGA;
            ctb_r <= adcc_pkg::RST_CFGB;
        end
        else if (wr)
        begin
            if (addr == adcc_pkg::ADDR_C1A)
                c1a_r <= module_data_port & adcc_pkg::MASK_CFGA; // [RL13] [RL14]
            else if (addr == adcc_pkg::ADDR_C1B)
                c1b_r <= module_data_port & adcc_pkg::MASK_CFGB; // [RL16]
            else if (addr == adcc_pkg::ADDR_C2A)
                c2a_r <= module_data_port & adcc_pkg::MASK_CFGA; // [RL15]
            else if (addr == adcc_pkg::ADDR_C2B)
                c2b_r <= module_data_port & adcc_pkg::MASK_CFGB; // [RL16]
            else if (addr == adcc_pkg::ADDR_CTA)
                cta_r <= module_data_port & adcc_pkg::MASK_CTA; // [RL17]
            else if (addr == adcc_pkg::ADDR_CTB)
                ctb_r <= module_data_port & adcc_pkg::MASK_CTB; // [RL18]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            data1_r <= adcc_pkg::RST_DATA;
            data2_r <= adcc_pkg::RST_DATA;
            datat_r <= adcc_pkg::RST_DATA;
        end
        else if (state_r == adcc_pkg::ST_STORE)
        begin
            case (tgt_r)
                adcc_pkg::TGT_ONE:  data1_r <= conv_result_in; // [RL22] [RL2]
                adcc_pkg::TGT_TWO:  data2_r <= conv_result_in; // [RL22] [RL3]
                default:            datat_r <= conv_result_in; // [RL22] [RL4]
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state_r <= adcc_pkg::ST_IDLE;
            tgt_r   <= adcc_pkg::TGT_ONE;
        end
        else
        begin
            case (state_r)
                adcc_pkg::ST_IDLE:
                begin
                    if (launch_now)
                    begin
                        state_r <= adcc_pkg::ST_CONV;
                        tgt_r   <= tgt_nxt;
                    end
                end
                adcc_pkg::ST_CONV:
                begin
                    if (timer_done)
                        state_r <= adcc_pkg::ST_STORE;
                end
                default:
                    state_r <= adcc_pkg::ST_IDLE;
            endcase
        end
    end

    // Halt rises with the writing of a start bit that launches a conversion, falls at result capture
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            cpu_halt <= 1'b0;
        else if (wr && addr == adcc_pkg::ADDR_CTRL && launches(module_data_port & adcc_pkg::MASK_CTRL))
            cpu_halt <= 1'b1; // [RL5]
        else if (state_r == adcc_pkg::ST_STORE)
            cpu_halt <= 1'b0; // [RL5]
    end

    // Front-end settings latched for the whole conversion
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            conv_active         <= 1'b0;
            fe_diff             <= 1'b1;
            fe_gain_fixed       <= 1'b0;
            fe_gain             <= 5'h00;
            fe_clock_code       <= 3'h0;
            fe_resolution       <= 3'h0;
            fe_offset_sign      <= 1'b0;
            fe_offset_magnitude <= 3'h0;
            fe_bias             <= 3'h7;
            fe_reference        <= 2'h0;
            fe_source           <= 4'h0;
            fe_target           <= adcc_pkg::TGT_ONE;
        end
        else if (launch_now)
        begin
            conv_active         <= 1'b1;
            fe_diff             <= se == adcc_pkg::SE_DIFF; // [RL7] [RL8]
            fe_gain_fixed       <= se >= adcc_pkg::SE_FIXED_LO && se <= adcc_pkg::SE_FIXED_HI; // [RL12]
            fe_gain             <= sel_a[adcc_pkg::GAIN_LSB +: 5]; // [RL13] [RL15] [RL17]
            fe_clock_code       <= sel_a[adcc_pkg::CLK_LSB +: 3]; // [RL13]
            fe_resolution       <= sel_a[adcc_pkg::RES_LSB +: 3]; // [RL13]
            fe_offset_sign      <= sel_a[adcc_pkg::OFF_SIGN]; // [RL14]
            fe_offset_magnitude <= sel_a[adcc_pkg::OFF_LSB +: 3]; // [RL14]
            fe_bias             <= sel_b[adcc_pkg::BIAS_LSB +: 3]; // [RL16] [RL18]
            fe_reference        <= sel_b[adcc_pkg::REF_LSB +: 2]; // [RL16] [RL18]
            fe_source           <= se; // [RL10] [RL11]
            fe_target           <= tgt_nxt; // [RL10]
        end
        else if (timer_done)
        begin
            conv_active <= 1'b0;
        end
    end

    adcc_conv_timer #(
        .DIV_SHIFT (DIV_SHIFT)
    ) u_timer (
        .clk        (clk),
        .rst_b      (rst_sync_b),
        .start      (launch_now),
        .clock_code (sel_a[adcc_pkg::CLK_LSB +: 3]),
        .res_code   (sel_a[adcc_pkg::RES_LSB +: 3]),
        .tick       (conv_tick),
        .done       (timer_done)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_b);

    property p_halt_conv;
        !idle |-> cpu_halt;
    endproperty
    a_halt_conv: assert property (p_halt_conv) else $error("CPU running during conversion"); // [RL5]

    property p_start_clear;
        state_r == adcc_pkg::ST_STORE |=> ctrl_r[2:0] == 3'h0 && !cpu_halt && idle;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("Start bits not cleared"); // [RL6]

    property p_ch1_first;
        launch_now && ctrl_r[adcc_pkg::START_ONE] |=> fe_target == adcc_pkg::TGT_ONE && conv_active;
    endproperty
    a_ch1_first: assert property (p_ch1_first) else $error("Sensor one lost priority"); // [RL7]

    property p_ch2_next;
        launch_now && ctrl_r[2:1] == 2'b01 |=> fe_target == adcc_pkg::TGT_TWO;
    endproperty
    a_ch2_next: assert property (p_ch2_next) else $error("Sensor two not chosen"); // [RL8]

    property p_temp_conv;
        launch_now && ctrl_r[2:0] == 3'b001 |=> fe_target == adcc_pkg::TGT_TEMP && fe_diff;
    endproperty
    a_temp_conv: assert property (p_temp_conv) else $error("Temperature not converted"); // [RL4]

    property p_temp_drop;
        idle && ctrl_r[2:0] == 3'b001 && se != 4'h0 && !xfer |=> idle && !ctrl_r[0] && !cpu_halt;
    endproperty
    a_temp_drop: assert property (p_temp_drop) else $error("Temperature ran with nonzero source"); // [RL9]

    property p_fixed_gain;
        conv_active && fe_source inside {[4'h4:4'h7]} |-> fe_gain_fixed;
    endproperty
    a_fixed_gain: assert property (p_fixed_gain) else $error("Fixed gain not forced"); // [RL12]

    property p_result_hold;
        state_r != adcc_pkg::ST_STORE |=> $stable(data1_r) && $stable(data2_r) && $stable(datat_r);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("Result changed outside completion"); // [RL22]

    property p_unused_zero;
        (ctrl_r & ~adcc_pkg::MASK_CTRL) == 16'h0000 && (ctb_r & ~adcc_pkg::MASK_CTB) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("Unused bit set"); // [RL23]

    property p_action_done;
        xfer && !module_action_wr |=> !module_action_busy && module_read_strobe == $past(act_read_r);
    endproperty
    a_action_done: assert property (p_action_done) else $error("Action bit not cleared"); // [RL21]

    property p_ch1_fields;
        launch_now && tgt_nxt == adcc_pkg::TGT_ONE |=> fe_clock_code == c1a_r[10:8] && fe_gain == c1a_r[15:11];
    endproperty
    a_ch1_fields: assert property (p_ch1_fields) else $error("Sensor one fields misrouted"); // [RL13]

    c_ch1_conv: cover property (state_r == adcc_pkg::ST_STORE && tgt_r == adcc_pkg::TGT_ONE);
    c_temp_conv: cover property (state_r == adcc_pkg::ST_STORE && tgt_r == adcc_pkg::TGT_TEMP);
    c_temp_drop: cover property (temp_drop);
    c_read: cover property (module_read_strobe);

endmodule : adcc_top
`default_nettype wire

//--- adcc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcc_cpu_model (
    // Clock
    input  wire logic        clk,
    // Answer
    input  wire logic        busy,
    input  wire logic        strobe,
    input  wire logic [15:0] rdata,
    // Request
    output var  logic [15:0] data,
    output var  logic [15:0] addr,
    output var  logic        act_wr,
    output var  logic [15:0] act
);
    initial
    begin
        data = 16'h0000;
        addr = 16'h0000;
        act_wr = 1'b0;
        act = 16'h0000;
    end

    // Ports stay loaded until busy falls; a read overwrites the data port
    task automatic xfer(input logic [7:0] a, input logic [15:0] d, input logic rd,
                        output logic [15:0] q, output logic ok);
        int n;
        addr <= {8'h00, a};
        data <= d;
        act <= {1'b1, rd, 14'h0000};
        act_wr <= 1'b1;
        @(posedge clk);
        act_wr <= 1'b0;
        ok = 1'b0;
        q = 16'h0000;
        for (n = 0; n < 4000 && !ok; n++)
        begin
            @(posedge clk);
            if (busy === 1'b0 && (!rd || strobe === 1'b1))
            begin
                ok = 1'b1;
                q = rdata;
            end
        end
        // A read reloads the data port; one edge passes before the next request
        if (rd)
        begin
            data <= q;
            @(posedge clk);
        end
    endtask : xfer
endmodule : adcc_cpu_model
`default_nettype wire

//--- test_adcc_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_adcc_top;
    logic        clk;
    logic        rst_b;
    logic [15:0] res_in;
    logic [15:0] d_p, a_p, act_p, rdata;
    logic        act_wr, busy, strobe, halt, active, tick;
    logic        f_diff, f_fix, f_sign;
    logic [4:0]  f_gain;
    logic [2:0]  f_clk, f_res, f_mag, f_bias, f_tgt;
    logic [1:0]  f_ref;
    logic [3:0]  f_src;
    int          mismatches, n_tests, cycles, i;
    wire  [28:0] snap = {f_diff, f_fix, f_gain, f_clk, f_res, f_sign, f_mag, f_bias, f_ref, f_src, f_tgt};
    localparam logic [19:0] F1 = {5'h0B, 3'h2, 3'h0, 1'b1, 3'h3, 3'h5, 2'h2};
    localparam logic [19:0] F2 = {5'h11, 3'h3, 3'h1, 1'b1, 3'h4, 3'h6, 2'h1};
    localparam logic [19:0] FT = {5'h00, 3'h1, 3'h0, 1'b0, 3'h5, 3'h3, 2'h0};
    localparam logic [7:0]  UA [8] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h01, 8'h0A};
    localparam logic [15:0] UE [8] = '{16'hFF7F, 16'h0073, 16'hFF7F, 16'h0073, 16'h077F, 16'h0070, 0, 0};
    localparam logic [15:0] CV [6] = '{16'h5A0B, 16'h0052, 16'h8B1C, 16'h0061, 16'h0105, 16'h0030};

    adcc_cpu_model cpu (.clk(clk), .busy(busy), .strobe(strobe), .rdata(rdata), .data(d_p),
                        .addr(a_p), .act_wr(act_wr), .act(act_p));

    adcc_top #(.DIV_SHIFT(8)) dut (.clk(clk), .rst_b(rst_b), .module_data_port(d_p),
        .module_address_port(a_p), .module_action_wr(act_wr), .module_action_port(act_p),
        .module_action_busy(busy), .module_read_data(rdata), .module_read_strobe(strobe),
        .cpu_halt(halt), .conv_result_in(res_in), .conv_active(active), .conv_tick(tick),
        .fe_diff(f_diff), .fe_gain_fixed(f_fix), .fe_gain(f_gain), .fe_clock_code(f_clk),
        .fe_resolution(f_res), .fe_offset_sign(f_sign), .fe_offset_magnitude(f_mag),
        .fe_bias(f_bias), .fe_reference(f_ref), .fe_source(f_src), .fe_target(f_tgt));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic        ok;
        cpu.xfer(a, d, 1'b0, q, ok);
        chk(ok, 1);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        logic        ok;
        cpu.xfer(a, 16'h0000, 1'b1, q, ok);
        chk({ok, q}, {1'b1, e});
    endtask : rdchk

    // Starts a conversion, checks the latched settings and its length
    task automatic conv(input logic [15:0] c, input logic [15:0] r, input logic [28:0] e, input int cyc);
        int n;
        int act_n;
        int tick_n;
        res_in <= r;
        wr(8'h00, c);
        for (n = 0; n < 20 && active !== 1'b1; n++)
            @(posedge clk);
        chk(snap, e);
        chk(halt, 1);
        act_n = 0;
        tick_n = 0;
        for (n = 0; n < 4000 && halt === 1'b1; n++)
        begin
            @(posedge clk);
            if (active === 1'b1)
                act_n++;
            if (tick === 1'b1)
                tick_n++;
        end
        chk({active, act_n >= cyc && act_n <= cyc + 2}, 1);
        chk(tick_n, cyc);
        rdchk(8'h00, c & 16'hFF00);
    endtask : conv

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim;
        end
    end

    initial
    begin
        rst_b = 1'b0;
        res_in = 16'h0000;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 11; i++)
            rdchk(8'(i), (i == 3 || i == 6 || i == 9) ? 16'h0070 : 16'h0000);
        for (i = 0; i < 8; i++)
        begin
            wr(UA[i], 16'hFFFF);
            rdchk(UA[i], UE[i]);
        end
        for (i = 0; i < 6; i++)
            wr(UA[i], CV[i]);
        conv(16'h0007, 16'h1111, {2'b10, F1, 4'h0, 3'b001}, 256);
        rdchk(8'h01, 16'h1111);
        rdchk(8'h04, 16'h0000);
        conv(16'h0003, 16'h2222, {2'b10, F2, 4'h0, 3'b010}, 320);
        rdchk(8'h04, 16'h2222);
        rdchk(8'h01, 16'h1111);
        conv(16'h0001, 16'h3333, {2'b10, FT, 4'h0, 3'b100}, 256);
        rdchk(8'h07, 16'h3333);
        for (i = 1; i < 10; i++)
        begin
            conv({4'h0, 4'(i), 8'h06}, 16'h0A00 + 16'(i), {1'b0, i >= 4 && i <= 7, F1, 4'(i), 3'b001}, 256);
            rdchk(8'h01, 16'h0A00 + 16'(i));
        end
        wr(8'h00, 16'h0301);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            chk({halt, active}, 0);
        end
        rdchk(8'h00, 16'h0300);
        rdchk(8'h07, 16'h3333);
        end_sim;
    end
endmodule : test_adcc_top
`default_nettype wire
